/* hw/dacs_core.sv */
// Summary of operation
// - Both mode pins low: two-channel mode, pair select picks the input.
// - One conversion takes sixteen external clock cycles.
// - Trigger rise moves both sample-and-hold stages to hold at once.
// - Busy rises at conversion start and stays high through the conversion.
// - With count pin low, first falling clock edge latches pair select as next channel.
// - Chip select low enables serial outputs; high keeps them undriven.
// - A valid serial bit stands at each of the sixteen rising edges.
// - Frame: channel flag, converter flag, twelve result bits, two zeros.
// - Port pin high, count pin low: all data leaves on output A.
// - Single-output mode: output B floats from the next conversion start.
// - Single-output mode takes 32 cycles; every second trigger ignored.
// - Count pin high: channels alternate, pair select ignored.
// - Count pin high, port pin low: both outputs A and B active.
// - Both mode pins high: output A only, B floats, second trigger ignored.
// - Separate read strobe: data valid after third clock following its fall.
// - Trigger rise holds both stages and starts both converters together.
// - Count pin picks fixed-pair or auto-alternating channel operation.
`timescale 1ns/1ps
module dacs_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dacs_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dacs_pkg::dacs_pins_t pins,
  input wire dacs_pkg::dacs_ain_t ain,
  output logic busy,
  output logic hold,
  output logic sdo_a,
  output logic sdo_a_oe,
  output logic sdo_b,
  output logic sdo_b_oe
);

  typedef struct packed {
    dacs_pkg::dacs_state_t state;
    logic clk_p;
    logic trig_p;
    logic rd_p;
    logic chan_q;
    logic cur_chan;
    logic hold;
    logic busy;
    logic single;
    logic b_on;
    logic started;
    logic fell_first;
    logic [dacs_pkg::EDGE_BITS-1:0] edges;
    logic [1:0] rd_wait;
    logic [dacs_pkg::FRAME_BITS-1:0] sh_a;
    logic [dacs_pkg::FRAME_BITS-1:0] sh_b;
    logic oe_a;
    logic oe_b;
    logic ctrl_en;
    logic [15:0] conv_cnt;
    logic [dacs_pkg::RESULT_BITS-1:0] last_a;
    logic [dacs_pkg::RESULT_BITS-1:0] last_b;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dacs_core_st_t;

  localparam dacs_core_st_t ST_RST = '{
    state: dacs_pkg::DACS_IDLE,
    ctrl_en: dacs_pkg::CTRL_EN_RST,
    default: '0
  };

  dacs_pkg::dacs_pins_t sp;
  dacs_core_st_t st_q;
  dacs_core_st_t st_d;
  logic clk_rise;
  logic clk_fall;
  logic trig_rise;
  logic rd_fall;
  logic accept;

  dacs_sync #(
    .WIDTH($bits(dacs_pkg::dacs_pins_t))
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(pins),
    .dout(sp)
  );

  function automatic logic [dacs_pkg::RESULT_BITS-1:0] pick(
    input dacs_pkg::dacs_ain_t v,
    input logic chan,
    input logic conv_b
  );
    if (conv_b) begin
      pick = chan ? v.b1 : v.b0;
    end else begin
      pick = chan ? v.a1 : v.a0;
    end
  endfunction : pick

  function automatic logic [dacs_pkg::FRAME_BITS-1:0] frame(
    input logic chan,
    input logic conv_b,
    input logic [dacs_pkg::RESULT_BITS-1:0] res
  );
    frame = {chan, conv_b, res, 2'b00};
  endfunction : frame

  assign clk_rise = sp.adc_clk & ~st_q.clk_p;
  assign clk_fall = ~sp.adc_clk & st_q.clk_p;
  assign trig_rise = sp.trig & ~st_q.trig_p;
  assign rd_fall = ~sp.rd_n & st_q.rd_p;
  // Triggers outside idle are dropped: busy, or the B frame of single-output mode
  assign accept = trig_rise && st_q.ctrl_en && (st_q.state == dacs_pkg::DACS_IDLE);

  always_comb begin
    logic hit;
    logic [31:0] rd_val;
    hit = 1'b0;
    rd_val = '0;
    st_d = st_q;
    st_d.clk_p = sp.adc_clk;
    st_d.trig_p = sp.trig;
    st_d.rd_p = sp.rd_n;

    case (st_q.state)
      dacs_pkg::DACS_IDLE: begin
        if (accept) begin
          st_d.hold = 1'b1;
          st_d.busy = 1'b1;
          st_d.single = sp.out_port;
          st_d.b_on = ~sp.out_port;
          st_d.started = 1'b1;
          st_d.cur_chan = st_q.chan_q;
          st_d.fell_first = 1'b0;
          st_d.edges = '0;
          st_d.rd_wait = '0;
          // Both converters sample the same channel together
          st_d.sh_a = frame(st_q.chan_q, 1'b0, pick(ain, st_q.chan_q, 1'b0));
          st_d.sh_b = frame(st_q.chan_q, 1'b1, pick(ain, st_q.chan_q, 1'b1));
          st_d.last_a = pick(ain, st_q.chan_q, 1'b0);
          st_d.last_b = pick(ain, st_q.chan_q, 1'b1);
          st_d.conv_cnt = st_q.conv_cnt + 16'h0001;
          st_d.state = dacs_pkg::DACS_CONV;
        end
      end
      dacs_pkg::DACS_CONV: begin
        if (clk_fall) begin
          st_d.sh_a = {st_q.sh_a[dacs_pkg::FRAME_BITS-2:0], 1'b0};
          st_d.sh_b = {st_q.sh_b[dacs_pkg::FRAME_BITS-2:0], 1'b0};
          if (!st_q.fell_first) begin
            st_d.fell_first = 1'b1;
            if (sp.chan_cnt) begin
              st_d.chan_q = ~st_q.cur_chan;
            end else begin
              st_d.chan_q = sp.pair_sel;
            end
          end
        end
        if (clk_rise) begin
          st_d.edges = st_q.edges + 5'h01;
          if (st_q.edges == dacs_pkg::LAST_EDGE) begin
            st_d.busy = 1'b0;
            st_d.hold = 1'b0;
            st_d.edges = '0;
            if (st_q.single) begin
              // B frame is loaded on the next fall, after A's last bit has stood
              st_d.fell_first = 1'b0;
              st_d.state = dacs_pkg::DACS_SECOND;
            end else begin
              st_d.state = dacs_pkg::DACS_IDLE;
            end
          end
        end
      end
      dacs_pkg::DACS_SECOND: begin
        if (clk_fall) begin
          if (!st_q.fell_first) begin
            st_d.fell_first = 1'b1;
            // B result follows on output A as a second frame
            st_d.sh_a = frame(st_q.cur_chan, 1'b1, st_q.last_b);
          end else begin
            st_d.sh_a = {st_q.sh_a[dacs_pkg::FRAME_BITS-2:0], 1'b0};
          end
        end
        if (clk_rise) begin
          st_d.edges = st_q.edges + 5'h01;
          if (st_q.edges == dacs_pkg::LAST_EDGE) begin
            st_d.edges = '0;
            st_d.state = dacs_pkg::DACS_IDLE;
          end
        end
      end
      default: begin
        st_d.state = dacs_pkg::DACS_IDLE;
      end
    endcase

    // A strobe falling in cycle one is the tied trigger and blanks nothing
    if (rd_fall && st_q.state != dacs_pkg::DACS_IDLE && st_q.edges != '0) begin
      st_d.rd_wait = dacs_pkg::RD_DELAY;
    end else if (clk_rise && st_q.rd_wait != '0) begin
      st_d.rd_wait = st_q.rd_wait - 2'h1;
    end

    // Mode I/III keep B; II/IV route all to A
    st_d.oe_a = st_q.started && !sp.cs_n && st_q.ctrl_en && st_q.rd_wait == '0;
    st_d.oe_b = st_d.oe_a && st_q.b_on;

    // APB: one wait state, answer registered for clean outputs
    st_d.pready = 1'b0;
    st_d.pslverr = 1'b0;
    if (paddr == dacs_pkg::OFS_CTRL) begin
      hit = 1'b1;
      rd_val[dacs_pkg::CTRL_EN_BIT] = st_q.ctrl_en;
    end else if (paddr == dacs_pkg::OFS_STATUS) begin
      hit = 1'b1;
      rd_val[11:0] = {st_q.started, st_q.b_on, st_q.single, st_q.chan_q, st_q.cur_chan,
                      st_q.hold, st_q.busy, st_q.state, sp.chan_cnt, sp.out_port};
    end else if (paddr == dacs_pkg::OFS_COUNT) begin
      hit = 1'b1;
      rd_val[15:0] = st_q.conv_cnt;
    end else if (paddr == dacs_pkg::OFS_LAST_A) begin
      hit = 1'b1;
      rd_val[dacs_pkg::RESULT_BITS-1:0] = st_q.last_a;
    end else if (paddr == dacs_pkg::OFS_LAST_B) begin
      hit = 1'b1;
      rd_val[dacs_pkg::RESULT_BITS-1:0] = st_q.last_b;
    end
    if (psel && penable && !st_q.pready) begin
      st_d.pready = 1'b1;
      st_d.pslverr = ~hit;
      st_d.prdata = pwrite ? 32'h0000_0000 : rd_val;
    end
    if (psel && penable && st_q.pready && pwrite && paddr == dacs_pkg::OFS_CTRL) begin
      st_d.ctrl_en = pwdata[dacs_pkg::CTRL_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign busy = st_q.busy;
  assign hold = st_q.hold;
  assign sdo_a = st_q.sh_a[dacs_pkg::FRAME_BITS-1];
  assign sdo_b = st_q.sh_b[dacs_pkg::FRAME_BITS-1];
  assign sdo_a_oe = st_q.oe_a;
  assign sdo_b_oe = st_q.oe_b;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_busy_start: assert property (accept |=> busy ##1 busy)
    else $error("busy not raised at conversion start");
  a_hold_now: assert property (accept |=> hold)
    else $error("hold not entered on trigger");
  a_cs_quiet: assert property (sp.cs_n |=> !sdo_a_oe && !sdo_b_oe)
    else $error("serial output driven with chip select high");
  a_single_b_off: assert property (accept && sp.out_port |=> ##1 !sdo_b_oe)
    else $error("output B driven in single-output mode");
  a_second_ignored: assert property (
    st_q.state == dacs_pkg::DACS_SECOND && trig_rise |=> st_q.state != dacs_pkg::DACS_CONV
  )
    else $error("trigger accepted during second frame");
  a_frame_tail: assert property (
    st_q.state == dacs_pkg::DACS_CONV && st_q.edges == dacs_pkg::LAST_EDGE |-> !sdo_a && !sdo_b
  )
    else $error("frame tail bit not zero");
  a_chan_auto: assert property (
    st_q.state == dacs_pkg::DACS_CONV && clk_fall && !st_q.fell_first && sp.chan_cnt
    |=> st_q.chan_q == !st_q.cur_chan
  )
    else $error("channel did not alternate");
  a_pair_pick: assert property (
    st_q.state == dacs_pkg::DACS_CONV && clk_fall && !st_q.fell_first && !sp.chan_cnt
    |=> st_q.chan_q == $past(sp.pair_sel)
  )
    else $error("pair select not latched");
  a_sixteen_end: assert property (
    st_q.state == dacs_pkg::DACS_CONV && clk_rise && st_q.edges == dacs_pkg::LAST_EDGE
    |=> !busy && st_q.state != dacs_pkg::DACS_CONV
  )
    else $error("conversion did not end after sixteen clocks");
  a_rd_blank: assert property (
    rd_fall && st_q.state != dacs_pkg::DACS_IDLE && st_q.edges != '0 |=> ##1 !sdo_a_oe
  )
    else $error("data driven before read delay elapsed");

endmodule : dacs_core

/* hw/dacs_pkg.sv */
package dacs_pkg;

  localparam int RESULT_BITS = 12;
  localparam int FRAME_BITS = 16;
  localparam int EDGE_BITS = 5;
  localparam int APB_AW = 8;

  // Register byte offsets
  localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [APB_AW-1:0] OFS_COUNT = 8'h08;
  localparam logic [APB_AW-1:0] OFS_LAST_A = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_LAST_B = 8'h10;

  // Field positions and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;

  // Timing counts, in external clock cycles
  localparam logic [EDGE_BITS-1:0] LAST_EDGE = 5'h0f;
  localparam logic [1:0] RD_DELAY = 2'h3;

  // Least trigger high time, kept by the controller
  localparam int TRIG_MIN_NS = 15;
  localparam int PCLK_NS = 20;
  localparam int TRIG_MIN_CYC = (TRIG_MIN_NS + PCLK_NS - 1) / PCLK_NS;

  typedef enum logic [2:0] {
    DACS_IDLE = 3'b001,
    DACS_CONV = 3'b010,
    DACS_SECOND = 3'b100
  } dacs_state_t;

  typedef struct packed {
    logic trig;
    logic rd_n;
    logic cs_n;
    logic chan_cnt;
    logic out_port;
    logic pair_sel;
    logic adc_clk;
  } dacs_pins_t;

  typedef struct packed {
    logic [RESULT_BITS-1:0] a0;
    logic [RESULT_BITS-1:0] a1;
    logic [RESULT_BITS-1:0] b0;
    logic [RESULT_BITS-1:0] b1;
  } dacs_ain_t;

endpackage : dacs_pkg

/* hw/dacs_sync.sv */
`timescale 1ns/1ps
module dacs_sync #(
  parameter int WIDTH = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } dacs_sync_st_t;

  dacs_sync_st_t st_q;
  dacs_sync_st_t st_d;

  always_comb begin
    st_d.meta = din;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.stable;

endmodule : dacs_sync

/* sim/dacs_host.sv */
`timescale 1ns/1ps
module dacs_host (
  input wire logic pclk,
  input wire logic [3:0] cfg,
  input wire logic sdo_a,
  input wire logic sdo_a_oe,
  input wire logic sdo_b,
  input wire logic sdo_b_oe,
  input wire logic busy,
  input wire logic hold,
  output dacs_pkg::dacs_pins_t pins
);
  logic trig_q = 1'b0;
  logic clk_q = 1'b0;
  logic [31:0] sa = '0;
  logic [31:0] sb = '0;
  logic [31:0] bs = '0;
  logic aoe = 1'b0;
  logic boe = 1'b0;
  logic rd_q = 1'b1;
  int rd_at = -1;
  int gap = 0;

  // Read strobe kept separate and high, except one fall when rd_at is set
  assign pins = {trig_q, rd_q, cfg, clk_q};

  // Clock stands low between frames; a released line is taken as z
  task automatic run(input int n);
    sa = '0;
    sb = '0;
    bs = '0;
    aoe = 1'b0;
    boe = 1'b0;
    gap = 0;
    @(posedge pclk);
    trig_q <= 1'b1;
    repeat (dacs_pkg::TRIG_MIN_CYC) @(posedge pclk);
    trig_q <= 1'b0;
    repeat (6) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      // Second trigger halfway through the run, in the conversion or the B frame, must be refused
      if (i == n / 2)
        trig_q <= 1'b1;
      clk_q <= 1'b1;
      rd_q <= (i == rd_at) ? 1'b0 : 1'b1;
      gap = gap + (sdo_a_oe ? 0 : 1);
      sa = {sa[30:0], sdo_a_oe ? sdo_a : 1'bz};
      sb = {sb[30:0], sdo_b_oe ? sdo_b : 1'bz};
      bs = {bs[30:0], busy & hold};
      aoe = aoe | sdo_a_oe;
      boe = boe | sdo_b_oe;
      repeat (5) @(posedge pclk);
      trig_q <= 1'b0;
      clk_q <= 1'b0;
      repeat (5) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
  endtask : run
endmodule : dacs_host

/* sim/dual_adc_conversion_serial_out_tb.sv */
`timescale 1ns/1ps
module dual_adc_conversion_serial_out_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, busy, hold, sdo_a, sdo_a_oe, sdo_b, sdo_b_oe, err;
  logic cur = 1'b0;
  logic [3:0] cfg = 4'h0;
  logic [11:0] res [4] = '{12'h5a3, 12'h0c7, 12'hf18, 12'h8e6};
  dacs_pkg::dacs_pins_t pins;
  int errors = 0;
  int num_checks = 0;

  always #10 pclk = ~pclk;

  dacs_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .ain({res[0], res[1], res[2], res[3]}), .busy(busy),
    .hold(hold), .sdo_a(sdo_a), .sdo_a_oe(sdo_a_oe), .sdo_b(sdo_b), .sdo_b_oe(sdo_b_oe));

  dacs_host host_u (.pclk(pclk), .cfg(cfg), .sdo_a(sdo_a), .sdo_a_oe(sdo_a_oe),
    .sdo_b(sdo_b), .sdo_b_oe(sdo_b_oe), .busy(busy), .hold(hold), .pins(pins));

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      errors++;
      print_verdict();
    end
  endtask : apb

  // One conversion; cfg is {cs_n, chan_cnt, out_port, pair_sel}
  task automatic conv(input logic [3:0] c);
    logic [15:0] fa;
    logic [15:0] fb;
    logic one;
    one = c[1];
    fa = {cur, 1'b0, res[{1'b0, cur}], 2'b00};
    fb = {cur, 1'b1, res[{1'b1, cur}], 2'b00};
    @(posedge pclk);
    cfg <= c;
    host_u.run(one ? 32 : 16);
    if (one)
      check(host_u.sa, {fa, fb});
    else if (!c[3])
      check({host_u.sa[15:0], host_u.sb[15:0]}, {fa, fb});
    check(host_u.bs, one ? 32'hffff0000 : 32'h0000ffff);
    check({30'h0, host_u.aoe, host_u.boe}, {30'h0, ~c[3], ~c[3] & ~one});
    cur = c[2] ? ~cur : c[0];
  endtask : conv

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check({30'h0, sdo_a_oe, sdo_b_oe}, 32'h0);
    apb(1'b0, dacs_pkg::OFS_CTRL, 32'h0, rd, err);
    check(rd, 32'h1);
    apb(1'b0, 8'h14, 32'h0, rd, err);
    check({31'h0, err}, 32'h1);
    // Pair select chosen so that, with count pin high, it differs from the alternating channel
    for (int k = 0; k < 8; k++)
      conv({1'b0, k[2:1], k[0] ^ k[2]});
    // Separate strobe falling at clock 5 blanks three sampled bits
    @(posedge pclk);
    cfg <= 4'h0;
    host_u.rd_at = 4;
    host_u.run(16);
    host_u.rd_at = -1;
    check(host_u.gap, 32'h3);
    cur = 1'b0;
    conv(4'h8);
    apb(1'b1, dacs_pkg::OFS_CTRL, 32'h0, rd, err);
    host_u.run(16);
    check(host_u.bs, 32'h0);
    apb(1'b1, dacs_pkg::OFS_CTRL, 32'h1, rd, err);
    apb(1'b0, dacs_pkg::OFS_COUNT, 32'h0, rd, err);
    check(rd, 32'ha);
    print_verdict();
  end
endmodule : dual_adc_conversion_serial_out_tb
